// ===== src/tpg_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpg_defs.svh"

// Operation
// [RQ1] divide oscillator by 64 for six-times clock
// [RQ2] divide by six into three 120-degree references
// [RQ3] two-burst: reference AND oscillator AND six-times; the code gates the 120-degree window, not the reference
// [RQ4] bursts start at delay angle and plus 60
// [RQ5] pulses follow oscillator, half high half low
// [RQ6] single-burst: 120-degree window AND oscillator only
// [RQ7] profile selectable between two and single burst
// [RQ8] phase detectors XOR mains and gate reference
// [RQ9] detected phase sequence steers detector references
// [RQ10] six gate outputs, two per phase
// [RQ11] instant enable gates outputs, low suppresses immediately
// [RQ12] reset clears dividers, holds gates low
module tpg_top (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       osc_384f,
    input  wire logic [2:0] mains_ref,
    input  wire logic       profile_sel,
    input  wire logic       inst_en,
    output var  logic [5:0] gate_cmd,
    output var  logic [2:0] phase_det,
    output var  logic       clk_6f,
    output var  logic       seq_rev
);

    localparam logic [5:0] WIN [6] = '{`TPG_WIN_PA, `TPG_WIN_NA, `TPG_WIN_PB,
                                       `TPG_WIN_NB, `TPG_WIN_PC, `TPG_WIN_NC};
    localparam logic [5:0] REF [3] = '{`TPG_REF_A, `TPG_REF_B, `TPG_REF_C};
    localparam logic [`TPG_HI_W-1:0] HI_HALF = `TPG_HI_W'(`TPG_DIV_HI / 2);

    tpg_div_if #(.W(`TPG_HI_W)) hi_if ();
    tpg_div_if #(.W(`TPG_LO_W)) lo_if ();

    tpg_pkg::tpg_state_t   state_r;
    tpg_pkg::tpg_profile_t prof;
    logic                  osc_r;
    logic                  osc_q;
    logic                  osc_fall;
    logic                  clk6_w;
    logic [2:0]            sixth;
    logic [2:0]            gref;
    logic [2:0]            pd_ref;
    logic [5:0]            gate_nxt;
    logic [5:0]            gate_cmd_r;
    logic [2:0]            phase_det_r;
    logic                  clk_6f_r;
    logic                  seq_rev_r;
    logic                  mains_a_q;

    // window lookup: is this sixth inside the mask
    function automatic logic in_sixth(input logic [5:0] mask, input logic [2:0] s);
        in_sixth = (s <= `TPG_SIXTH_MAX) ? mask[s] : 1'b0;
    endfunction

    // oscillator level registered, then edge found
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            osc_r <= 1'b0;
            osc_q <= 1'b0;
        end
        else
        begin
            osc_r <= osc_384f;
            osc_q <= osc_r;
        end
    end

    // step on the falling edge: count and sixth then stay put for a whole high phase,
    // so no gate pulse straddles a step and spills past its window
    assign osc_fall = !osc_r && osc_q;

    // first stage: oscillator down to six times mains
    assign hi_if.tick = osc_fall; // [RQ1]
    tpg_divider #(.DIV(`TPG_DIV_HI), .W(`TPG_HI_W)) u_div_hi (
        .clk  (clk),
        .rstn (rstn),
        .dif  (hi_if)
    );

    // second stage: six steps per mains period
    assign lo_if.tick = hi_if.wrap; // [RQ2]
    tpg_divider #(.DIV(`TPG_DIV_LO), .W(`TPG_LO_W)) u_div_lo (
        .clk  (clk),
        .rstn (rstn),
        .dif  (lo_if)
    );

    assign sixth  = lo_if.cnt;
    assign clk6_w = hi_if.cnt < HI_HALF; // [RQ1] 50% square at six times mains
    assign prof   = tpg_pkg::tpg_profile_t'(profile_sel); // [RQ7]

    // three 50% references spaced 120 degrees
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_ref
            assign gref[i] = in_sixth(REF[i], sixth); // [RQ2]
        end
    endgenerate

    // hold gates off until the dividers have completed a step
    always_ff @(posedge clk)
    begin
        if (!rstn)
            state_r <= tpg_pkg::tpg_st_wait;
        else
        begin
            case (state_r)
                tpg_pkg::tpg_st_wait: if (lo_if.wrap || hi_if.wrap) state_r <= tpg_pkg::tpg_st_run;
                tpg_pkg::tpg_st_run:  state_r <= tpg_pkg::tpg_st_run;
                default:              state_r <= tpg_pkg::tpg_st_wait;
            endcase
        end
    end

    // gate commands: window AND oscillator, AND six-times in two-burst
    generate
        for (genvar k = 0; k < 6; k++)
        begin : g_gate
            assign gate_nxt[k] = (state_r == tpg_pkg::tpg_st_run) && inst_en // [RQ11]
                && in_sixth(WIN[k], sixth) // [RQ4] [RQ6] [RQ10]
                && osc_r // [RQ5]
                && ((prof == tpg_pkg::tpg_prof_one) || clk6_w); // [RQ3] [RQ6]
        end
    endgenerate

    // registered gate outputs
    always_ff @(posedge clk)
    begin
        if (!rstn)
            gate_cmd_r <= 6'h00; // [RQ12]
        else
            gate_cmd_r <= gate_nxt;
    end

    // phase sequence: sample phase b at rising edge of phase a
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mains_a_q <= 1'b1; // no false rise if phase a is already high
            seq_rev_r <= 1'b0;
        end
        else
        begin
            mains_a_q <= mains_ref[0];
            if (mains_ref[0] && !mains_a_q)
                seq_rev_r <= mains_ref[1]; // [RQ9]
        end
    end

    // reverse sequence swaps the b and c references
    assign pd_ref[0] = gref[0];
    assign pd_ref[1] = seq_rev_r ? gref[2] : gref[1]; // [RQ9]
    assign pd_ref[2] = seq_rev_r ? gref[1] : gref[2]; // [RQ9]

    // phase detectors and six-times clock output
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            phase_det_r <= 3'h0;
            clk_6f_r    <= 1'b0;
        end
        else
        begin
            phase_det_r <= mains_ref ^ pd_ref; // [RQ8]
            clk_6f_r    <= clk6_w;
        end
    end

    assign gate_cmd  = gate_cmd_r;
    assign phase_det = phase_det_r;
    assign clk_6f    = clk_6f_r;
    assign seq_rev   = seq_rev_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_hi_wrap;
        (osc_fall && hi_if.cnt == `TPG_HI_W'(`TPG_DIV_HI - 1)) |=> hi_if.wrap ##1 hi_if.cnt == '0;
    endproperty
    a_hi_wrap: assert property (p_hi_wrap) else $error("first stage did not roll at 64"); // [RQ1]

    property p_sixth_step;
        hi_if.wrap |=> ##1 (sixth == (($past(sixth, 2) == `TPG_SIXTH_MAX) ? 3'h0
                                      : $past(sixth, 2) + 3'h1));
    endproperty
    a_sixth_step: assert property (p_sixth_step) else $error("sixth did not advance by one"); // [RQ2]

    property p_two_burst;
        (prof == tpg_pkg::tpg_prof_two) ##1 gate_cmd_r[0] |-> $past(clk6_w) && $past(osc_r);
    endproperty
    a_two_burst: assert property (p_two_burst) else $error("two-burst gate outside clocks"); // [RQ3]

    property p_window;
        gate_cmd_r[0] |-> ($past(sixth) == 3'h0) || ($past(sixth) == 3'h1);
    endproperty
    a_window: assert property (p_window) else $error("gate +a outside its window"); // [RQ4]

    property p_pulse_osc;
        gate_cmd_r[2] |-> $past(osc_r);
    endproperty
    a_pulse_osc: assert property (p_pulse_osc) else $error("gate pulse while oscillator low"); // [RQ5]

    property p_one_burst;
        (prof == tpg_pkg::tpg_prof_one && inst_en && osc_r && state_r == tpg_pkg::tpg_st_run
         && (sixth == 3'h4 || sixth == 3'h5)) |=> gate_cmd_r[4];
    endproperty
    a_one_burst: assert property (p_one_burst) else $error("single burst pulse missing"); // [RQ6]

    property p_phase_det;
        !seq_rev_r |=> phase_det_r[1] == ($past(mains_ref[1]) ^ $past(gref[1]));
    endproperty
    a_phase_det: assert property (p_phase_det) else $error("phase detector mismatch"); // [RQ8]

    property p_seq;
        (mains_ref[0] && !mains_a_q) |=> seq_rev_r == $past(mains_ref[1]);
    endproperty
    a_seq: assert property (p_seq) else $error("sequence not captured"); // [RQ9]

    property p_pair;
        !(gate_cmd_r[0] && gate_cmd_r[1]);
    endproperty
    a_pair: assert property (p_pair) else $error("both gates of phase a on"); // [RQ10]

    property p_inhibit;
        !inst_en |=> gate_cmd_r == 6'h00;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("gate while instant enable low"); // [RQ11]

    property p_reset;
        @(posedge clk) disable iff (1'b0) !rstn |=> gate_cmd_r == 6'h00 && sixth == 3'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not clear"); // [RQ12]

    c_two: cover property ((prof == tpg_pkg::tpg_prof_two) && gate_cmd_r[0]);
    c_one: cover property ((prof == tpg_pkg::tpg_prof_one) && gate_cmd_r[5]);
    c_rev: cover property ($rose(seq_rev_r));
    c_off: cover property (gate_cmd_r[3] ##1 !inst_en);

endmodule

`default_nettype wire

// ===== src/tpg_defs.svh
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// oscillator runs at 384 times mains; divided down in two stages
`define TPG_OSC_MULT  384
`define TPG_DIV_HI    64
`define TPG_DIV_LO    6
`define TPG_HI_W      6
`define TPG_LO_W      3

// one bit per sixth of the mains period (60 degrees each)
`define TPG_REF_A     6'h07
`define TPG_REF_B     6'h1C
`define TPG_REF_C     6'h31

// 120 degree gate windows: +a, -a, +b, -b, +c, -c
`define TPG_WIN_PA    6'h03
`define TPG_WIN_NA    6'h18
`define TPG_WIN_PB    6'h0C
`define TPG_WIN_NB    6'h21
`define TPG_WIN_PC    6'h30
`define TPG_WIN_NC    6'h06

`define TPG_SIXTH_MAX 3'h5

`endif

// ===== src/tpg_pkg.sv
package tpg_pkg;

    // gate pulse profile select
    typedef enum logic {
        tpg_prof_two,
        tpg_prof_one
    } tpg_profile_t;

    // output state after reset
    typedef enum logic {
        tpg_st_wait,
        tpg_st_run
    } tpg_state_t;

endpackage

// ===== src/tpg_div_if.sv
`timescale 1ns/10ps
`default_nettype none

// counting stage: advance strobe in, count and wrap pulse out
interface tpg_div_if #(
    parameter int W = 6
);
    logic         tick;
    logic [W-1:0] cnt;
    logic         wrap;

    modport div  (input tick, output cnt, output wrap);
    modport user (output tick, input cnt, input wrap);
endinterface

`default_nettype wire

// ===== src/tpg_divider.sv
`timescale 1ns/10ps
`default_nettype none

module tpg_divider #(
    parameter int DIV = 64,
    parameter int W   = 6
) (
    input  wire logic clk,
    input  wire logic rstn,
    tpg_div_if.div    dif
);

    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_r;
    logic         wrap_r;

    generate
        if (DIV < 2 || W < $clog2(DIV))
        begin : g_bad
            $error("tpg_divider: DIV must be at least 2 and fit in W bits");
        end
    endgenerate

    // modulo counter, stepping on each strobe
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cnt_r <= '0;
        else if (dif.tick)
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + W'(1);
    end

    // one-cycle pulse when the count rolls over
    always_ff @(posedge clk)
    begin
        if (!rstn)
            wrap_r <= 1'b0;
        else
            wrap_r <= dif.tick && (cnt_r == LAST);
    end

    assign dif.cnt  = cnt_r;
    assign dif.wrap = wrap_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_div_range;
        cnt_r <= LAST;
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider count out of range");

    property p_div_hold;
        !dif.tick |=> (cnt_r == $past(cnt_r)) && !wrap_r;
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divider moved without strobe");

endmodule

`default_nettype wire

// ===== verif/tpg_drv_model.sv
`timescale 1ns/10ps
`default_nettype none

// gate transformer drivers: count the pulses that reach each one
module tpg_drv_model (
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic [5:0] gate_cmd,
    output var  logic [7:0] cnt [6]
);
    logic [5:0] prev_r;

    // one count per rising gate edge, six separate channels
    always_ff @(posedge clk)
    begin
        prev_r <= gate_cmd;
        for (int k = 0; k < 6; k++)
        begin
            if (clr)
                cnt[k] <= 8'h00;
            else if (gate_cmd[k] && !prev_r[k])
                cnt[k] <= cnt[k] + 8'h01;
        end
    end
endmodule

`default_nettype wire

// ===== verif/test_three_phase_gate_pulse_timing.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpg_defs.svh"

module test_three_phase_gate_pulse_timing;
    localparam logic [5:0] RA = `TPG_REF_A;
    localparam logic [5:0] RB = `TPG_REF_B;
    localparam logic [5:0] RC = `TPG_REF_C;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        osc_384f = 1'b0;
    logic [2:0]  mains_ref = 3'h0;
    logic        profile_sel = 1'b0;
    logic        inst_en = 1'b1;
    logic        rev = 1'b0;
    logic        clr = 1'b0;
    logic [5:0]  gate_cmd;
    logic [2:0]  phase_det;
    logic        clk_6f;
    logic        seq_rev;
    logic [7:0]  cnt [6];
    logic [1:0]  osc_cnt = 2'h0;
    logic [10:0] mcnt = 11'h000;
    int          mismatches = 0;
    int          comparisons = 0;

    always #5 clk = ~clk;

    // oscillator of four clk, mains of 1536 clk, optional reversed order
    always @(posedge clk)
    begin
        osc_cnt <= osc_cnt + 2'h1;
        osc_384f <= osc_cnt[1];
        mcnt <= (mcnt == 11'h5FF) ? 11'h000 : mcnt + 11'h001;
        mains_ref <= {rev ? RB[mcnt[10:8]] : RC[mcnt[10:8]],
                      rev ? RC[mcnt[10:8]] : RB[mcnt[10:8]], RA[mcnt[10:8]]};
    end

    tpg_top i_dut (.clk(clk), .rstn(rstn), .osc_384f(osc_384f), .mains_ref(mains_ref),
        .profile_sel(profile_sel), .inst_en(inst_en), .gate_cmd(gate_cmd),
        .phase_det(phase_det), .clk_6f(clk_6f), .seq_rev(seq_rev));

    tpg_drv_model i_drv (.clk(clk), .clr(clr), .gate_cmd(gate_cmd), .cnt(cnt));

    task automatic test_done;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait for a level of the six-times clock
    task automatic wait_6f(input logic v);
        int i;
        i = 0;
        while (clk_6f !== v && i < 600)
        begin
            cyc(1);
            i++;
        end
        if (i == 600)
        begin
            $display("[FAIL] clk_6f wait expected %0d seen timeout", v);
            mismatches++;
            test_done;
        end
    endtask

    // reset clears outputs and holds gates until the dividers wrap
    task automatic test_reset;
        int bad;
        int i;
        bad = 0;
        i = 0;
        // restart part way into a mains period so the detectors see a clear offset
        cyc(1);
        while (mcnt != 11'h280 && i < 1600)
        begin
            cyc(1);
            i++;
        end
        if (i == 1600)
        begin
            $display("[FAIL] mains align expected %0d seen timeout", 11'h280);
            mismatches++;
            test_done;
        end
        rstn <= 1'b0;
        cyc(3);
        chk("gate_cmd in reset", 32'h0, gate_cmd);
        chk("clk_6f in reset", 32'h0, clk_6f);
        rstn <= 1'b1;
        repeat (200)
        begin
            cyc(1);
            bad += (gate_cmd !== 6'h00);
        end
        chk("gates after reset", 32'h0, bad);
        $display("test reset done");
    endtask

    // six-times clock: 32 oscillator periods high, 32 low
    task automatic test_6f;
        int n;
        wait_6f(1'b0);
        wait_6f(1'b1);
        for (n = 0; clk_6f === 1'b1 && n < 600; n++)
            cyc(1);
        chk("clk_6f high", 32'd128, n);
        for (n = 0; clk_6f === 1'b0 && n < 600; n++)
            cyc(1);
        chk("clk_6f low", 32'd128, n);
        $display("test clk_6f done");
    endtask

    // pulses per mains period on every gate channel
    task automatic test_gates(input logic prof, input logic en, input logic [31:0] exp);
        profile_sel <= prof;
        cyc(1600);
        inst_en <= en;
        cyc(1);
        if (!en)
            chk("gate_cmd after disable", 32'h0, gate_cmd);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(1536);
        for (int k = 0; k < 6; k++)
            chk($sformatf("pulses gate %0d", k), exp, cnt[k]);
        inst_en <= 1'b1;
        $display("test gates profile %0d enable %0d done", prof, en);
    endtask

    // detectors see equal offsets over one mains period when steering follows the order
    task automatic pd_check;
        int h [3];
        h = '{0, 0, 0};
        repeat (1536)
        begin
            cyc(1);
            for (int k = 0; k < 3; k++)
                h[k] += (phase_det[k] === 1'b1);
        end
        chk("phase_det b high count", h[0], h[1]);
        chk("phase_det c high count", h[0], h[2]);
        chk("phase_det a partly high", 32'h1, (h[0] > 0) && (h[0] < 1536));
    endtask

    // phase order detection from the mains comparators
    task automatic test_seq;
        cyc(3200);
        chk("seq_rev forward", 32'h0, seq_rev);
        pd_check;
        rev <= 1'b1;
        cyc(3200);
        chk("seq_rev reversed", 32'h1, seq_rev);
        pd_check;
        rev <= 1'b0;
        cyc(3200);
        chk("seq_rev forward again", 32'h0, seq_rev);
        $display("test sequence done");
    endtask

    initial
    begin
        cyc(8);
        rstn <= 1'b1;
        test_reset;
        test_6f;
        test_gates(1'b0, 1'b1, 32'd64);
        test_gates(1'b1, 1'b1, 32'd128);
        test_gates(1'b0, 1'b0, 32'd0);
        test_seq;
        test_done;
    end
endmodule

`default_nettype wire
